// >>> cfg_link_if.sv
// Link between the host controller and the configuration/mode store.
// Assumes both ends share the core clock; no clocking block.
interface cfg_link_if;
  logic       serial_select_n;  // Active-low select, driven by host
  logic       cmd_valid;        // One-cycle command byte strobe
  logic [7:0] cmd_byte;
  logic       cfg_wr;           // One-cycle configuration write strobe
  logic [5:0] cfg_addr;
  logic       cfg_val;
  logic       rd_start;         // One-cycle start of a data record read
  logic       remote_reset;     // One-cycle remote reset request
  logic       read_swap;        // Device: swap pending for next read

  modport device (
    input  serial_select_n, cmd_valid, cmd_byte, cfg_wr, cfg_addr, cfg_val,
    input  rd_start, remote_reset,
    output read_swap
  );
  modport host (
    output serial_select_n, cmd_valid, cmd_byte, cfg_wr, cfg_addr, cfg_val,
    output rd_start, remote_reset,
    input  read_swap
  );
endinterface : cfg_link_if

// >>> cfg_link_properties.sv
// Link checker for the configuration/mode store and its host.
// Assumes all link signals are sampled on the shared core clock.
module cfg_link_properties (
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic       serial_select_n,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       cfg_wr,
  input wire logic [5:0] cfg_addr,
  input wire logic       cfg_val,
  input wire logic       rd_start,
  input wire logic       remote_reset,
  input wire logic       read_swap
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  // Swap command seen on the byte lane
  wire ff_cmd = cmd_valid && (cmd_byte == 8'hff);

  // Frame steps: select cycle with no strobe, then one strobe
  sequence s_sel;
    !serial_select_n && !cfg_wr && !cmd_valid && !rd_start;
  endsequence
  sequence s_strobe;
    cfg_wr || cmd_valid || rd_start;
  endsequence

  property p_frame;
    $fell(serial_select_n) |-> s_sel ##1 s_strobe;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame without select-then-strobe");
  property p_cmd_sel;
    cmd_valid |-> !serial_select_n && !$past(serial_select_n);
  endproperty
  a_cmd_sel: assert property (p_cmd_sel)
    else $error("command byte outside select");
  property p_wr_sel;
    cfg_wr |-> !serial_select_n ##1 (serial_select_n && !cfg_wr);
  endproperty
  a_wr_sel: assert property (p_wr_sel)
    else $error("config write not framed by select");
  // Address and value settle a cycle before the strobe
  property p_wr_setup;
    cfg_wr |-> $stable(cfg_addr) && $stable(cfg_val);
  endproperty
  a_wr_setup: assert property (p_wr_setup)
    else $error("config address or value moved at the write strobe");
  property p_rd_sel;
    rd_start |-> !serial_select_n ##1 (serial_select_n && !rd_start);
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("read start not framed by select");
  property p_rr_sel;
    remote_reset |-> serial_select_n ##1 !remote_reset;
  endproperty
  a_rr_sel: assert property (p_rr_sel)
    else $error("remote reset sent with select low");
  property p_swap_set;
    ff_cmd && !serial_select_n && !rd_start |=> read_swap;
  endproperty
  a_swap_set: assert property (p_swap_set)
    else $error("swap command not recorded");
  property p_swap_use;
    rd_start && !serial_select_n && !ff_cmd |=> !read_swap;
  endproperty
  a_swap_use: assert property (p_swap_use)
    else $error("swap not consumed by read");
  property p_swap_hold;
    read_swap && !rd_start && !remote_reset && !$rose(serial_select_n) |=> read_swap;
  endproperty
  a_swap_hold: assert property (p_swap_hold)
    else $error("pending swap lost before read");
  property p_rr_drop;
    remote_reset |=> !read_swap;
  endproperty
  a_rr_drop: assert property (p_rr_drop)
    else $error("remote reset kept pending swap");
endmodule // cfg_link_properties

// >>> cfg_mode_host.sv
// Host end: turns user requests into framed link transactions.
// Assumes one request at a time, handed over with a valid/ready pair.
module cfg_mode_host
  import cfg_mode_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  cfg_link_if.host        link,
  input  wire logic       i_req_valid,
  input  wire logic [1:0] i_req_kind,
  input  wire logic [7:0] i_req_byte,
  input  wire logic       i_read_swap,
  input  wire logic       i_prog_supply_high,
  output logic            o_req_ready,
  output logic            o_refused,
  output logic            o_read_swapped
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SEL  = 5'h02,
    ST_SWAP = 5'h04,
    ST_ACT  = 5'h08,
    ST_REL  = 5'h10
  } host_state_t;

  host_state_t state;
  logic [1:0]  kind;
  logic [7:0]  byte_q;
  logic        want_swap;
  logic        blocked;

  // A clear of the source bit is unsafe with the supply high
  always_comb begin
    blocked = (i_req_kind == REQ_CMD) && !i_req_byte[CMD_VAL_POS]
            && (i_req_byte[6:4] == CMD_MARK)
            && (i_req_byte[3:1] == MODE_SRC_SHADOW)
            && i_prog_supply_high;
    o_req_ready = (state == ST_IDLE);
  end

  // Framing sequence: select (skipped for remote reset), optional swap, action, release
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state     <= ST_IDLE;
      kind      <= REQ_CMD;
      byte_q    <= 8'h00;
      want_swap <= 1'b0;
      o_refused <= 1'b0;
    end else begin
      o_refused <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_req_valid && blocked) begin
            o_refused <= 1'b1;
          end else if (i_req_valid) begin
            kind      <= i_req_kind;
            byte_q    <= i_req_byte;
            want_swap <= i_read_swap && (i_req_kind == REQ_READ);
            state     <= (i_req_kind == REQ_RESET) ? ST_ACT : ST_SEL;
          end
        end
        ST_SEL: begin
          state <= want_swap ? ST_SWAP : ST_ACT;
        end
        ST_SWAP: begin
          state <= ST_ACT;
        end
        ST_ACT: begin
          state <= ST_REL;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Link outputs; select low only inside a frame
  always_comb begin
    link.serial_select_n = !(state == ST_SEL || state == ST_SWAP
                           || (state == ST_ACT && kind != REQ_RESET));
    link.cmd_valid = (state == ST_SWAP)
                   || (state == ST_ACT && kind == REQ_CMD);
    link.cmd_byte  = (state == ST_SWAP) ? CMD_SWAP : byte_q;
    link.cfg_wr    = (state == ST_ACT && kind == REQ_CFG);
    link.cfg_addr  = byte_q[6:1];
    link.cfg_val   = byte_q[0];
    link.rd_start  = (state == ST_ACT && kind == REQ_READ);
    link.remote_reset = (state == ST_ACT && kind == REQ_RESET);
  end

  // Swap seen by the device at the read start
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_read_swapped <= 1'b0;
    end else if (link.rd_start) begin
      o_read_swapped <= link.read_swap;
    end
  end

endmodule : cfg_mode_host

// >>> cfg_mode_pkg.sv
// Constants and helpers shared by the configuration/mode store and its host.
// Assumes one 25 MHz core clock for both ends of the link.
package cfg_mode_pkg;

  // Clock and configuration array sizes
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned N_CFG_BITS   = 56;
  localparam int unsigned N_MODE_BITS  = 8;
  localparam int unsigned ADDR_W       = 6;

  // Configuration bit addresses (field LSB / MSB)
  localparam logic [5:0] OSC_TRIM_LSB      = 6'h30;  // 48
  localparam logic [5:0] OSC_TRIM_MSB      = 6'h31;  // 49
  localparam logic [5:0] LINE_SCALE_LSB    = 6'h32;  // 50
  localparam logic [5:0] LINE_SCALE_MSB    = 6'h33;  // 51
  localparam logic [5:0] EXTRA_GAIN_ADDR   = 6'h34;  // 52
  localparam logic [5:0] TAMPER_THR_ADDR   = 6'h35;  // 53
  localparam logic [5:0] STEPPER_TYPE_ADDR = 6'h36;  // 54
  localparam logic [5:0] RESERVED_ADDR     = 6'h37;  // 55
  localparam logic [5:0] SYS_CLEAR_ADDR    = 6'h00;  // Clear-all bit position

  // Mode bit indices
  localparam logic [2:0] MODE_OSC_START  = 3'h0;
  localparam logic [2:0] MODE_PUMP       = 3'h1;
  localparam logic [2:0] MODE_RSVD_A     = 3'h2;
  localparam logic [2:0] MODE_RSVD_B     = 3'h3;
  localparam logic [2:0] MODE_CUR_CHAN   = 3'h4;
  localparam logic [2:0] MODE_SRC_SHADOW = 3'h5;
  localparam logic [2:0] MODE_OTP_BURN   = 3'h6;
  localparam logic [2:0] MODE_READ_SWAP  = 3'h7;

  // Command byte layout: value, 111, index, don't care
  localparam int unsigned CMD_VAL_POS  = 7;
  localparam logic [2:0]  CMD_MARK     = 3'h7;
  localparam logic [7:0]  CMD_SWAP     = 8'hff;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [55:0] SHADOW_RESET = 56'h0;

  // Decoded field values
  localparam logic signed [4:0] TRIM_PLUS_PCT  = 5'sh0a;  // +10 %
  localparam logic signed [4:0] TRIM_MINUS_PCT = -5'sh0a; // -10 %
  localparam logic [6:0] SCALE_BASE_64TH = 7'h17;         // 0.3594 = 23/64
  localparam logic [6:0] SCALE_STEP_64TH = 7'h02;         // 0.03125 per step
  localparam logic [3:0] EXTRA_GAIN_ADD  = 4'h8;
  localparam logic [2:0] TAMPER_SHIFT_LO = 3'h3;          // 12.5 % = 1/8
  localparam logic [2:0] TAMPER_SHIFT_HI = 3'h4;          // 6.25 % = 1/16

  // Stepper pulse widths in microseconds and derived cycle counts
  localparam real STEP_5V_US = 31250.0;
  localparam real STEP_3V_US = 156250.0;
  localparam int unsigned STEP_5V_CYCLES = int'(STEP_5V_US * CLK_HZ / 1.0e6);
  localparam int unsigned STEP_3V_CYCLES = int'(STEP_3V_US * CLK_HZ / 1.0e6);

  // Host request kinds
  typedef enum logic [1:0] {
    REQ_CMD   = 2'h0,
    REQ_CFG   = 2'h1,
    REQ_READ  = 2'h2,
    REQ_RESET = 2'h3
  } req_kind_t;

  // Oscillator trim: 0 and 3 mean no trim
  function automatic logic signed [4:0] osc_trim_pct(input logic [1:0] f);
    case (f)
      2'h1:    osc_trim_pct = TRIM_PLUS_PCT;
      2'h2:    osc_trim_pct = TRIM_MINUS_PCT;
      default: osc_trim_pct = 5'sh00;
    endcase
  endfunction

  // Line voltage scale in 64ths, equal steps
  function automatic logic [6:0] line_scale(input logic [1:0] f);
    line_scale = SCALE_BASE_64TH + 7'(SCALE_STEP_64TH * f);
  endfunction

  // Data record served at a read slot (0-based records)
  function automatic logic [2:0] record_at(input logic [2:0] slot, input logic swap);
    record_at = swap ? {~slot[2], slot[1:0]} : slot;
  endfunction

endpackage : cfg_mode_pkg

// >>> cfg_mode_store.sv
// Device end: 56 configuration bits (antifuse and shadow copies) plus
// eight volatile mode signals, written over the host link.
// Assumes the link is synchronous to i_core_clk and strobes last one cycle.
//
// Notes on behaviour
// - Trim field: 0,3 none; 1 +10%; 2 -10%
// - Line scale field: 0.3594 to 0.4531, equal steps
// - Extra gain bit adds eight when set
// - Tamper threshold 12.5% or 6.25%
// - Stepper pulse 31.25 ms or 156.25 ms
// - Higher address is field MSB; 55 reserved
// - Fifty-six configuration bits, all but reserved 55 individually writable
// - Eight mode bits; POR clears, remote reset keeps all but the pending swap in bit 7
// - Command byte: value, 111, index, don't care
// - Pump bit turns pulse pins into pump drive
// - Channel bit picks current channel one or two
// - Source bit picks antifuse or shadow bits
// - Burn bit also writes antifuse elements
// - FF swaps record order of next read
// - Host resends FF before every swapped read
// - Clear bit wipes system signals on deselect
// - Clear bit set: only FF accepted
// - Source bit disconnects sense amps; host keeps it set while the programming supply is high
// - Oscillator start bit starts RC start-up
// - Host should program configuration during production
// - Six-bit address per bit, equal to index
// - Link works only while select is low, except remote reset, taken with select high
module cfg_mode_store
  import cfg_mode_pkg::*;
#(
  parameter int unsigned STEP_5V_CNT = STEP_5V_CYCLES,
  parameter int unsigned STEP_3V_CNT = STEP_3V_CYCLES,
  parameter logic [55:0] FUSE_INIT   = 56'h0
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_reset_n,
  cfg_link_if.device               link,
  input  wire logic                i_pulse_pos,
  input  wire logic                i_pulse_neg,
  input  wire logic                i_pump_phase,
  input  wire logic [2:0]          i_rec_slot,
  output logic [55:0]              o_cfg_active,
  output logic [7:0]               o_mode_data_record,
  output logic signed [4:0]        o_osc_trim_pct,
  output logic [6:0]               o_line_voltage_scale,
  output logic [3:0]               o_extra_current_gain,
  output logic [2:0]               o_tamper_threshold_shift,
  output logic [22:0]              o_stepper_pulse_cycles,
  output logic                     o_osc_start,
  output logic                     o_current_channel_choice,
  output logic                     o_sense_disconnect,
  output logic                     o_pulse_out_pos,
  output logic                     o_pulse_out_neg,
  output logic [2:0]               o_rec_index,
  output logic                     o_system_clear_done
);

  // Elaboration check on stepper counts
  if (STEP_5V_CNT < 1 || STEP_3V_CNT < 1 || STEP_5V_CNT > 23'h7fffff
      || STEP_3V_CNT > 23'h7fffff) begin : g_bad_step
    $error("stepper counts must fit 23 bits and be nonzero");
  end

  logic [55:0] shadow;
  logic [55:0] antifuse;
  logic [7:0]  mode;
  logic        swap_pending;
  logic        swap_active;
  logic        select_q;
  logic        dec_mode_wr;
  logic [2:0]  dec_index;
  logic        dec_value;
  logic        dec_swap;
  logic        clear_armed;
  logic        link_open;
  logic        cfg_take;
  logic        mode_take;
  logic        swap_take;
  logic        deselect;
  logic [55:0] cfg_sel;

  mode_cmd_decoder u_dec (
    .i_byte    (link.cmd_byte),
    .o_mode_wr (dec_mode_wr),
    .o_index   (dec_index),
    .o_value   (dec_value),
    .o_swap    (dec_swap)
  );

  // Qualified link events
  always_comb begin
    clear_armed = shadow[SYS_CLEAR_ADDR];
    link_open   = ~link.serial_select_n;
    cfg_take    = link_open && link.cfg_wr && !clear_armed
                && (link.cfg_addr < 6'(N_CFG_BITS))
                && (link.cfg_addr != RESERVED_ADDR);
    mode_take   = link_open && link.cmd_valid && dec_mode_wr
                && !clear_armed;
    swap_take   = link_open && link.cmd_valid && dec_swap;
    deselect    = link.serial_select_n && !select_q;              // Rising edge
  end

  // Select history for the idle-return edge
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      select_q <= 1'b1;
    end else begin
      select_q <= link.serial_select_n;
    end
  end

  // Shadow latches: one bit per address, wiped by the armed clear
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      shadow <= SHADOW_RESET;
    end else if (clear_armed && deselect) begin
      shadow <= SHADOW_RESET;
    end else if (cfg_take) begin
      shadow[link.cfg_addr] <= link.cfg_val;
    end
  end

  // Antifuse copy: a blown fuse cannot be unblown, so writes only set
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      antifuse <= FUSE_INIT;
    end else if (cfg_take && mode[MODE_OTP_BURN] && link.cfg_val) begin
      antifuse[link.cfg_addr] <= 1'b1;
    end
  end

  // Mode bits: power-on reset and the armed clear on deselect clear them, remote reset does not
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      mode <= MODE_RESET;
    end else if (clear_armed && deselect) begin
      mode <= MODE_RESET;
    end else if (mode_take) begin
      mode[dec_index] <= dec_value;
    end
  end

  // Swap is one-shot: consumed by the next read start
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      swap_pending <= 1'b0;
      swap_active  <= 1'b0;
    end else begin
      if (link_open && link.rd_start) begin
        swap_active  <= swap_pending || swap_take;
        swap_pending <= 1'b0;
      end else if (swap_take) begin
        swap_pending <= 1'b1;
      end else if (link.remote_reset) begin
        swap_pending <= 1'b0;
      end
    end
  end

  // Source choice; antifuse stays in effect with the bit clear
  always_comb begin
    cfg_sel = mode[MODE_SRC_SHADOW] ? shadow : antifuse;
  end

  // Registered decoded fields of the active configuration
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_cfg_active             <= '0;
      o_osc_trim_pct           <= 5'sh00;
      o_line_voltage_scale     <= SCALE_BASE_64TH;
      o_extra_current_gain     <= 4'h0;
      o_tamper_threshold_shift <= TAMPER_SHIFT_LO;
      o_stepper_pulse_cycles   <= 23'(STEP_5V_CNT);
    end else begin
      o_cfg_active   <= cfg_sel;
      // Field MSB sits at the higher address
      o_osc_trim_pct <= osc_trim_pct(cfg_sel[OSC_TRIM_MSB:OSC_TRIM_LSB]);
      o_line_voltage_scale
        <= line_scale(cfg_sel[LINE_SCALE_MSB:LINE_SCALE_LSB]);
      o_extra_current_gain
        <= cfg_sel[EXTRA_GAIN_ADDR] ? EXTRA_GAIN_ADD : 4'h0;
      o_tamper_threshold_shift
        <= cfg_sel[TAMPER_THR_ADDR] ? TAMPER_SHIFT_HI : TAMPER_SHIFT_LO;
      o_stepper_pulse_cycles
        <= cfg_sel[STEPPER_TYPE_ADDR] ? 23'(STEP_3V_CNT) : 23'(STEP_5V_CNT);
    end
  end

  // Mode-driven outputs and pulse pin steering
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_osc_start              <= 1'b0;
      o_current_channel_choice <= 1'b0;
      o_sense_disconnect       <= 1'b0;
      o_pulse_out_pos          <= 1'b0;
      o_pulse_out_neg          <= 1'b0;
      o_system_clear_done      <= 1'b0;
    end else begin
      o_osc_start              <= mode[MODE_OSC_START];
      o_current_channel_choice <= mode[MODE_CUR_CHAN];
      // Amps off the fuses whenever shadow is the source
      o_sense_disconnect       <= mode[MODE_SRC_SHADOW];
      if (mode[MODE_PUMP]) begin
        o_pulse_out_pos <= i_pump_phase;
        o_pulse_out_neg <= ~i_pump_phase;
      end else begin
        o_pulse_out_pos <= i_pulse_pos;
        o_pulse_out_neg <= i_pulse_neg;
      end
      o_system_clear_done <= clear_armed && deselect;
    end
  end

  // Record served at each slot of the current read
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_rec_index <= 3'h0;
    end else begin
      o_rec_index <= record_at(i_rec_slot, swap_active);
    end
  end

  // Mode record view; bit 7 shows a pending swap
  always_comb begin
    o_mode_data_record                 = mode;
    o_mode_data_record[MODE_READ_SWAP] = swap_pending;
    link.read_swap                     = swap_pending;
  end

endmodule : cfg_mode_store

// >>> mode_cmd_decoder.sv
// Decodes one command byte into a mode-bit write or the read-swap command.
// Purely combinational; caller qualifies with its own strobe.
module mode_cmd_decoder
  import cfg_mode_pkg::*;
(
  input  wire logic [7:0] i_byte,
  output logic            o_mode_wr,
  output logic [2:0]      o_index,
  output logic            o_value,
  output logic            o_swap
);
  // Top bit is the value, next three the mark, then index, LSB ignored
  always_comb begin
    o_index   = i_byte[3:1];
    o_value   = i_byte[CMD_VAL_POS];
    o_swap    = (i_byte == CMD_SWAP);
    o_mode_wr = (i_byte[6:4] == CMD_MARK)
              && (o_index != MODE_RSVD_A)
              && (o_index != MODE_RSVD_B)
              && (o_index != MODE_READ_SWAP);                 // Only via FF
  end
endmodule : mode_cmd_decoder

// >>> tb.sv
// Bench joining host and store over one link; drives host requests.
// Assumes the design package and link interface are compiled first.
module tb import cfg_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned S5 = 10;
  localparam int unsigned S3 = 50;
  logic              clk = 0, rst_n = 0, valid = 0, swp = 0, hi = 0;
  logic              ppos = 0, pneg = 0, phase = 0;
  logic [1:0]        kind = 0;
  logic [7:0]        byt = 0;
  logic [2:0]        slot = 0;
  logic [55:0]       act;
  logic [7:0]        mrec;
  logic signed [4:0] trim;
  logic [6:0]        scale;
  logic [3:0]        gain;
  logic [2:0]        tsh, ridx;
  logic [22:0]       steps;
  logic              osc, chan, disc, opos, oneg, cdone, ready, refd, rswp;
  logic              ref_seen = 0, done_seen = 0;
  int                failures = 0, num_checks = 0;

  cfg_link_if u_cfg_link_if ();
  cfg_mode_store #(.STEP_5V_CNT(S5), .STEP_3V_CNT(S3)) u_cfg_mode_store (
    .i_core_clk(clk), .i_reset_n(rst_n), .link(u_cfg_link_if),
    .i_pulse_pos(ppos), .i_pulse_neg(pneg), .i_pump_phase(phase),
    .i_rec_slot(slot), .o_cfg_active(act), .o_mode_data_record(mrec),
    .o_osc_trim_pct(trim), .o_line_voltage_scale(scale),
    .o_extra_current_gain(gain), .o_tamper_threshold_shift(tsh),
    .o_stepper_pulse_cycles(steps), .o_osc_start(osc),
    .o_current_channel_choice(chan), .o_sense_disconnect(disc),
    .o_pulse_out_pos(opos), .o_pulse_out_neg(oneg), .o_rec_index(ridx),
    .o_system_clear_done(cdone));
  cfg_mode_host u_cfg_mode_host (
    .i_core_clk(clk), .i_reset_n(rst_n), .link(u_cfg_link_if),
    .i_req_valid(valid), .i_req_kind(kind), .i_req_byte(byt),
    .i_read_swap(swp), .i_prog_supply_high(hi), .o_req_ready(ready),
    .o_refused(refd), .o_read_swapped(rswp));
  cfg_link_properties u_cfg_link_properties (
    .i_core_clk(clk), .i_reset_n(rst_n),
    .serial_select_n(u_cfg_link_if.serial_select_n),
    .cmd_valid(u_cfg_link_if.cmd_valid), .cmd_byte(u_cfg_link_if.cmd_byte),
    .cfg_wr(u_cfg_link_if.cfg_wr), .cfg_addr(u_cfg_link_if.cfg_addr),
    .cfg_val(u_cfg_link_if.cfg_val), .rd_start(u_cfg_link_if.rd_start),
    .remote_reset(u_cfg_link_if.remote_reset),
    .read_swap(u_cfg_link_if.read_swap));

  // Free-running core clock
  always #20 clk = ~clk;
  // One-cycle pulses are latched so checks need not hit the exact cycle
  always @(posedge clk) begin
    if (refd === 1'b1) ref_seen <= 1'b1;
    if (cdone === 1'b1) done_seen <= 1'b1;
  end

  task automatic chk(input string nm, input logic [55:0] exp, input logic [55:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One host request; idle cycles after let registered outputs settle
  task automatic req(input logic [1:0] k, input logic [7:0] b, input logic s);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) failures++;
    valid <= 1'b1;
    kind  <= k;
    byt   <= b;
    swp   <= s;
    @(posedge clk);
    valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    repeat (2) @(posedge clk);
  endtask
  task automatic cfgw(input logic [5:0] a, input logic v);
    req(2'h1, {1'b0, a, v}, 1'b0);
  endtask
  task automatic mode(input logic [2:0] i, input logic v);
    req(2'h0, {v, CMD_MARK, i, 1'b0}, 1'b0);
  endtask

  task automatic t_reset();
    chk("mrec", 0, mrec);
    chk("scale", 23, scale);
    chk("tsh", 3, tsh);
    chk("steps", S5, steps);
  endtask
  task automatic t_fields();
    cfgw(EXTRA_GAIN_ADDR, 1'b1);
    chk("gain_fuse", 0, gain);
    mode(MODE_SRC_SHADOW, 1'b1);
    chk("gain", 8, gain);
    chk("disc", 1, disc);
    for (int f = 0; f < 4; f++) begin
      cfgw(OSC_TRIM_LSB, f[0]);
      cfgw(OSC_TRIM_MSB, f[1]);
      cfgw(LINE_SCALE_LSB, f[0]);
      cfgw(LINE_SCALE_MSB, f[1]);
      chk("trim", f == 1 ? 5'h0a : f == 2 ? 5'h16 : 5'h00, $unsigned(trim));
      chk("scale", 23 + 2 * f, scale);
    end
    cfgw(TAMPER_THR_ADDR, 1'b1);
    chk("tsh", 4, tsh);
    cfgw(STEPPER_TYPE_ADDR, 1'b1);
    chk("steps", S3, steps);
    cfgw(RESERVED_ADDR, 1'b1);
    chk("rsvd", 0, act[55]);
    cfgw(6'h14, 1'b1);
    chk("bit20", 1, act[20]);
  endtask
  task automatic t_modes();
    mode(MODE_OSC_START, 1'b1);
    chk("osc", 1, osc);
    req(2'h0, 8'hf9, 1'b0);
    chk("chan", 1, chan);
    mode(MODE_RSVD_A, 1'b1);
    mode(MODE_RSVD_B, 1'b1);
    mode(MODE_READ_SWAP, 1'b1);
    chk("mrec", 8'h31, mrec);
    mode(MODE_PUMP, 1'b1);
    phase <= 1'b1;
    pneg  <= 1'b1;
    repeat (2) @(posedge clk);
    chk("pump", 2'b10, {opos, oneg});
    mode(MODE_PUMP, 1'b0);
    chk("pass", 2'b01, {opos, oneg});
  endtask
  task automatic t_burn();
    mode(MODE_OTP_BURN, 1'b1);
    cfgw(TAMPER_THR_ADDR, 1'b1);
    mode(MODE_OTP_BURN, 1'b0);
    mode(MODE_SRC_SHADOW, 1'b0);
    chk("tsh_fuse", 4, tsh);
    chk("gain_fuse", 0, gain);
    mode(MODE_SRC_SHADOW, 1'b1);
    hi <= 1'b1;
    mode(MODE_SRC_SHADOW, 1'b0);
    chk("refused", 1, ref_seen);
    chk("disc", 1, disc);
    hi <= 1'b0;
  endtask
  task automatic t_swap();
    slot <= 3'h1;
    req(2'h2, 8'h00, 1'b1);
    chk("swapped", 1, rswp);
    chk("ridx", 5, ridx);
    req(2'h2, 8'h00, 1'b0);
    chk("swapped", 0, rswp);
    chk("ridx", 1, ridx);
    req(2'h0, 8'hff, 1'b0);
    chk("mrec_ff", 8'hb1, mrec);
    req(2'h3, 8'h00, 1'b0);
    chk("mrec_rr", 8'h31, mrec);
  endtask
  task automatic t_clear();
    cfgw(SYS_CLEAR_ADDR, 1'b1);
    chk("mrec_clr", 0, mrec);
    chk("done", 1, done_seen);
    chk("tsh_clr", 4, tsh);
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_modes();
    t_burn();
    t_swap();
    t_clear();
    summarize();
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule // tb
